// >>> frame_delay_timer.sv
// frame delay timer gating when a response frame may start
`timescale 1ns/1ps
module frame_delay_timer
  import nfc_tag_regs_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // carrier and frame events
  input  wire logic                  carrier_tick,
  input  wire logic                  rx_frame_end,
  input  wire logic                  start_transmit_task,
  // configuration
  input  wire logic [OPEN_W-1:0]     window_open,
  input  wire logic [CLOSE_W-1:0]    window_close,
  input  wire timing_mode_type       mode,
  // results
  output logic                       tx_go,
  output logic                       tx_timeout,
  output logic                       tx_pending
);

  typedef struct packed {
    timer_state_type    state;
    logic [CLOSE_W-1:0] count;
    logic               pending;
    logic               go;
    logic               timeout;
  } timer_type;

  timer_type s_q;
  timer_type s_d;
  logic      in_window;
  logic      on_grid;

  always_comb begin
    s_d         = s_q;
    s_d.go      = 1'b0;
    s_d.timeout = 1'b0;
    in_window   = ({4'h0, window_open} <= s_q.count) && (s_q.count <= window_close);
    on_grid     = (s_q.count[GRID_LOG2-1:0] == '0);
    if (rx_frame_end) begin
      s_d.state = timer_running;
      s_d.count = '0;
    end else if (s_q.state == timer_running && carrier_tick && s_q.count != '1) begin
      s_d.count = s_q.count + 1'b1;
    end
    if (start_transmit_task) begin
      s_d.pending = 1'b1;
    end
    if (s_q.pending) begin
      case (mode)
        free_run_timing:       s_d.go = 1'b1;
        window_timing:         s_d.go = in_window;
        exact_timing:          s_d.go = (s_q.count == window_close);
        window_on_grid_timing: s_d.go = in_window && on_grid;
        default:               s_d.go = 1'b0;
      endcase
      s_d.timeout = !s_d.go && mode != free_run_timing && s_q.count > window_close;
      if (s_d.go || s_d.timeout) begin
        s_d.pending = 1'b0;
        s_d.state   = timer_stopped;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_go      = s_q.go;
  assign tx_timeout = s_q.timeout;
  assign tx_pending = s_q.pending;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_free_run;
    start_transmit_task && !s_q.pending && !s_q.go && mode == free_run_timing
      ##1 mode == free_run_timing |=> tx_go;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run start not sent");

  property p_window;
    tx_go && $past(mode) == window_timing |->
      $past(s_q.count) >= {4'h0, $past(window_open)} && $past(s_q.count) <= $past(window_close);
  endproperty
  a_window: assert property (p_window) else $error("window frame outside delays");

  property p_exact;
    tx_go && $past(mode) == exact_timing |-> $past(s_q.count) == $past(window_close);
  endproperty
  a_exact: assert property (p_exact) else $error("exact frame off maximum delay");

  property p_grid;
    tx_go && $past(mode) == window_on_grid_timing |->
      $past(s_q.count[GRID_LOG2-1:0]) == '0 && $past(s_q.count) <= $past(window_close);
  endproperty
  a_grid: assert property (p_grid) else $error("grid frame off bit grid");

  c_window_go: cover property (tx_go && mode == window_timing);
  c_timeout:   cover property (tx_timeout);

endmodule : frame_delay_timer

// >>> nfc_tag_frame_timing_regs.sv
// tag register bank: interrupt enables, status, field, frame timing, buffer
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module nfc_tag_frame_timing_regs
  import nfc_tag_regs_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [11:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // rf front end pins
  input  wire logic                 carrier_clock,
  input  wire logic                 field_sense,
  input  wire logic                 lock_sense,
  // tag core events and state
  input  wire logic                 rx_frame_end,
  input  wire logic                 sleep_request_valid,
  input  wire logic                 go_idle_task,
  input  wire logic                 go_sleep_task,
  input  wire logic                 start_transmit_task,
  input  wire logic [ERR_W-1:0]     error_set,
  input  wire logic [RXR_W-1:0]     rx_result_set,
  input  wire logic [STATE_W-1:0]   tag_operating_state,
  // buffer access
  input  wire logic [SIZE_W-1:0]    buffer_index,
  output logic [31:0]               buffer_address,
  output logic                      buffer_access_ok,
  // controls towards the tag core
  output logic [31:0]               irq_enable,
  output logic                      anticollision_sleep_state,
  output logic                      tx_go,
  output logic                      tx_timeout,
  output logic                      tx_pending,
  output logic                      tx_parity_enable,
  output logic                      unused_bit_drop_side,
  output logic                      tx_sof_enable,
  output logic                      tx_checksum_mode
);

  typedef struct packed {
    logic                car_meta;
    logic                car_sync;
    logic                car_prev;
    logic                fld_meta;
    logic                fld_sync;
    logic                lck_meta;
    logic                lck_sync;
    logic [31:0]         irq_en;
    logic [ERR_W-1:0]    err;
    logic [RXR_W-1:0]    rxr;
    sleep_state_type     sleep;
    logic [OPEN_W-1:0]   win_open;
    logic [CLOSE_W-1:0]  win_close;
    timing_mode_type     mode;
    logic [31:0]         ptr;
    logic [SIZE_W-1:0]   size;
    logic [FMT_W-1:0]    fmt;
    logic                ack;
    logic [31:0]         rdata;
    logic [31:0]         buf_addr;
    logic                buf_ok;
  } regs_type;

  regs_type    s_q;
  regs_type    s_d;
  logic        wr_hit;
  logic        rd_hit;
  logic [11:0] adr_word;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] merged;
  logic        carrier_tick;

  // byte lane enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : lane_mask

  // merge write data into an old value under a lane mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [31:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction : merge

  assign wr_hit       = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
  assign rd_hit       = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
  assign adr_word     = {wb_adr_i[11:2], 2'b00};
  assign wmask        = lane_mask(wb_sel_i);
  assign wbits        = wb_dat_i & wmask;
  assign carrier_tick = s_q.car_sync && !s_q.car_prev;

  always_comb begin
    s_d        = s_q;
    merged     = '0;
    // pin synchronisers and carrier edge finder
    s_d.car_meta = carrier_clock;
    s_d.car_sync = s_q.car_meta;
    s_d.car_prev = s_q.car_sync;
    s_d.fld_meta = field_sense;
    s_d.fld_sync = s_q.fld_meta;
    s_d.lck_meta = lock_sense;
    s_d.lck_sync = s_q.lck_meta;
    // bus answer one cycle after the request
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;

    // interrupt enables
    if (wr_hit && adr_word == OFS_INT_SET) begin
      s_d.irq_en = s_q.irq_en | (wbits & IRQ_IMPL_MASK);
    end
    if (wr_hit && adr_word == OFS_INT_DISABLE) begin
      s_d.irq_en = s_q.irq_en & ~wbits;
    end

    // write one to clear, new events win
    s_d.err = s_q.err;
    s_d.rxr = s_q.rxr;
    if (wr_hit && adr_word == OFS_ERROR) begin
      s_d.err = s_q.err & ~wbits[ERR_W-1:0];
    end
    if (wr_hit && adr_word == OFS_RX_RESULT) begin
      s_d.rxr = s_q.rxr & ~wbits[RXR_W-1:0];
    end
    s_d.err = s_d.err | error_set;
    s_d.rxr = s_d.rxr | rx_result_set;

    // anticollision sleep state, sleep wins a tie
    if (sleep_request_valid || go_sleep_task) begin
      s_d.sleep = sleep_a;
    end else if (go_idle_task) begin
      s_d.sleep = sleep_idle;
    end

    // read-write configuration
    if (wr_hit) begin
      case (adr_word)
        OFS_WIN_OPEN: begin
          merged       = merge({16'h0, s_q.win_open}, wb_dat_i, wmask);
          s_d.win_open = merged[OPEN_W-1:0];
        end
        OFS_WIN_CLOSE: begin
          merged        = merge({12'h0, s_q.win_close}, wb_dat_i, wmask);
          s_d.win_close = merged[CLOSE_W-1:0];
        end
        OFS_MODE: begin
          merged   = merge({30'h0, s_q.mode}, wb_dat_i, wmask);
          s_d.mode = timing_mode_type'(merged[1:0]);
        end
        OFS_PTR: begin
          s_d.ptr = merge(s_q.ptr, wb_dat_i, wmask);
        end
        OFS_SIZE: begin
          merged = merge({23'h0, s_q.size}, wb_dat_i, wmask);
          if (merged > SIZE_MAX) begin
            s_d.size = SIZE_MAX[SIZE_W-1:0];
          end else begin
            s_d.size = merged[SIZE_W-1:0];
          end
        end
        OFS_TX_FORMAT: begin
          merged  = merge({27'h0, s_q.fmt}, wb_dat_i, wmask);
          s_d.fmt = merged[FMT_W-1:0] & TX_FORMAT_RESET;
        end
        default: begin
          merged = '0;
        end
      endcase
    end

    // read mux, unused bits and unmapped words read zero
    if (rd_hit) begin
      case (adr_word)
        OFS_INT_SET:     s_d.rdata = s_q.irq_en;
        OFS_INT_DISABLE: s_d.rdata = s_q.irq_en;
        OFS_ERROR:       s_d.rdata = {28'h0, s_q.err};
        OFS_RX_RESULT:   s_d.rdata = {28'h0, s_q.rxr};
        OFS_TAG_STATE:   s_d.rdata = {29'h0, tag_operating_state};
        OFS_SLEEP:       s_d.rdata = {31'h0, s_q.sleep};
        OFS_FIELD:       s_d.rdata = {30'h0, s_q.lck_sync, s_q.fld_sync};
        OFS_WIN_OPEN:    s_d.rdata = {16'h0, s_q.win_open};
        OFS_WIN_CLOSE:   s_d.rdata = {12'h0, s_q.win_close};
        OFS_MODE:        s_d.rdata = {30'h0, s_q.mode};
        OFS_PTR:         s_d.rdata = s_q.ptr;
        OFS_SIZE:        s_d.rdata = {23'h0, s_q.size};
        OFS_TX_FORMAT:   s_d.rdata = {27'h0, s_q.fmt};
        default:         s_d.rdata = 32'h0000_0000;
      endcase
    end

    // buffer address and bound check
    s_d.buf_addr = s_q.ptr + {23'h0, buffer_index};
    s_d.buf_ok   = ({23'h0, buffer_index} < {23'h0, s_q.size});
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q           <= '0;
      s_q.win_open  <= WIN_OPEN_RESET;
      s_q.win_close <= WIN_CLOSE_RESET;
      s_q.mode      <= window_timing;
      s_q.fmt       <= TX_FORMAT_RESET;
      s_q.sleep     <= sleep_idle;
    end else begin
      s_q <= s_d;
    end
  end

  frame_delay_timer u_timer (
    .clock               (clock),
    .reset               (reset),
    .carrier_tick        (carrier_tick),
    .rx_frame_end        (rx_frame_end),
    .start_transmit_task (start_transmit_task),
    .window_open         (s_q.win_open),
    .window_close        (s_q.win_close),
    .mode                (s_q.mode),
    .tx_go               (tx_go),
    .tx_timeout          (tx_timeout),
    .tx_pending          (tx_pending)
  );

  assign wb_dat_o                  = s_q.rdata;
  assign wb_ack_o                  = s_q.ack;
  assign buffer_address            = s_q.buf_addr;
  assign buffer_access_ok          = s_q.buf_ok;
  assign irq_enable                = s_q.irq_en;
  assign anticollision_sleep_state = s_q.sleep;
  assign tx_parity_enable          = s_q.fmt[FMT_PARITY_BIT];
  assign unused_bit_drop_side      = s_q.fmt[FMT_DISCARD_BIT];
  assign tx_sof_enable             = s_q.fmt[FMT_SOF_BIT];
  assign tx_checksum_mode          = s_q.fmt[FMT_CRC_BIT];

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_irq_clear;
    wr_hit && adr_word == OFS_INT_DISABLE |=> (irq_enable & $past(wbits)) == 32'h0;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("disable write left enable");

  property p_irq_set;
    wr_hit && adr_word == OFS_INT_SET && wbits[IRQ_STARTED_BIT] |=> irq_enable[IRQ_STARTED_BIT];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("started enable not set");

  property p_w1c;
    wr_hit && adr_word == OFS_ERROR && error_set == '0 |=>
      s_q.err == ($past(s_q.err) & ~$past(wbits[ERR_W-1:0]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("error flags wrong after write");

  property p_set_wins;
    error_set[0] |=> s_q.err[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("error event lost");

  property p_sleep_idle;
    go_idle_task && !go_sleep_task && !sleep_request_valid |=> anticollision_sleep_state == sleep_idle;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep state not idle");

  property p_sleep_a;
    go_sleep_task || sleep_request_valid |=> anticollision_sleep_state == sleep_a;
  endproperty
  a_sleep_a: assert property (p_sleep_a) else $error("sleep state not set");

  property p_field;
    field_sense ##1 field_sense ##1 field_sense |=> s_q.fld_sync;
  endproperty
  a_field: assert property (p_field) else $error("field presence not shown");

  property p_buf_guard;
    buffer_access_ok |-> {23'h0, $past(buffer_index)} < {23'h0, $past(s_q.size)};
  endproperty
  a_buf_guard: assert property (p_buf_guard) else $error("access beyond buffer size");

  property p_lock;
    lock_sense ##1 lock_sense ##1 lock_sense |=> s_q.lck_sync;
  endproperty
  a_lock: assert property (p_lock) else $error("receiver lock not shown");

  property p_rx_w1c;
    wr_hit && adr_word == OFS_RX_RESULT && rx_result_set == '0 |=>
      s_q.rxr == ($past(s_q.rxr) & ~$past(wbits[RXR_W-1:0]));
  endproperty
  a_rx_w1c: assert property (p_rx_w1c) else $error("rx result wrong after write");

  property p_tag_state;
    rd_hit && adr_word == OFS_TAG_STATE |=> wb_dat_o == {29'h0, $past(tag_operating_state)};
  endproperty
  a_tag_state: assert property (p_tag_state) else $error("tag state read wrong");

  property p_close_write;
    wr_hit && adr_word == OFS_WIN_CLOSE && wmask == '1 |=>
      s_q.win_close == $past(wb_dat_i[CLOSE_W-1:0]);
  endproperty
  a_close_write: assert property (p_close_write) else $error("max delay not stored");

  property p_size_bound;
    s_q.size <= SIZE_MAX[SIZE_W-1:0];
  endproperty
  a_size_bound: assert property (p_size_bound) else $error("size above limit");

  property p_fmt_reserved;
    (s_q.fmt & ~TX_FORMAT_RESET) == '0;
  endproperty
  a_fmt_reserved: assert property (p_fmt_reserved) else $error("bad format bit");

  c_sleep:    cover property (go_sleep_task ##1 go_idle_task);
  c_irq_set:  cover property (wr_hit && adr_word == OFS_INT_SET);
  c_w1c:      cover property (wr_hit && adr_word == OFS_RX_RESULT && s_q.rxr != '0);
  c_tx_go:    cover property (tx_go);

endmodule : nfc_tag_frame_timing_regs

// >>> nfc_tag_regs_pkg.sv
// constants, field layouts and types shared by the tag register bank
package nfc_tag_regs_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_INT_SET     = 12'h304;
  localparam logic [11:0] OFS_INT_DISABLE = 12'h308;
  localparam logic [11:0] OFS_ERROR       = 12'h404;
  localparam logic [11:0] OFS_RX_RESULT   = 12'h40C;
  localparam logic [11:0] OFS_TAG_STATE   = 12'h410;
  localparam logic [11:0] OFS_SLEEP       = 12'h420;
  localparam logic [11:0] OFS_FIELD       = 12'h43C;
  localparam logic [11:0] OFS_WIN_OPEN    = 12'h504;
  localparam logic [11:0] OFS_WIN_CLOSE   = 12'h508;
  localparam logic [11:0] OFS_MODE        = 12'h50C;
  localparam logic [11:0] OFS_PTR         = 12'h510;
  localparam logic [11:0] OFS_SIZE        = 12'h514;
  localparam logic [11:0] OFS_TX_FORMAT   = 12'h518;

  // field widths
  localparam int OPEN_W  = 16;
  localparam int CLOSE_W = 20;
  localparam int SIZE_W  = 9;
  localparam int ERR_W   = 4;
  localparam int RXR_W   = 4;
  localparam int STATE_W = 3;
  localparam int FMT_W   = 5;

  // values after reset and limits
  localparam logic [OPEN_W-1:0]  WIN_OPEN_RESET  = 16'h0480;
  localparam logic [CLOSE_W-1:0] WIN_CLOSE_RESET = 20'h01000;
  localparam logic [FMT_W-1:0]   TX_FORMAT_RESET = 5'h17;
  localparam logic [31:0]        SIZE_MAX        = 32'h0000_0101;
  localparam logic [31:0]        IRQ_IMPL_MASK   = 32'h001C_5CFF;

  // field positions
  localparam int IRQ_STARTED_BIT   = 20;
  localparam int FMT_PARITY_BIT    = 0;
  localparam int FMT_DISCARD_BIT   = 1;
  localparam int FMT_SOF_BIT       = 2;
  localparam int FMT_CRC_BIT       = 4;
  localparam int FIELD_PRESENT_BIT = 0;
  localparam int FIELD_LOCK_BIT    = 1;

  // bit grid of 128 carrier cycles
  localparam int GRID_LOG2 = 7;

  typedef enum logic [1:0] {
    free_run_timing       = 2'b00,
    window_timing         = 2'b01,
    exact_timing          = 2'b10,
    window_on_grid_timing = 2'b11
  } timing_mode_type;

  typedef enum logic {
    sleep_idle = 1'b0,
    sleep_a    = 1'b1
  } sleep_state_type;

  typedef enum logic {
    timer_stopped = 1'b0,
    timer_running = 1'b1
  } timer_state_type;

endpackage : nfc_tag_regs_pkg

// >>> reader_field_model.sv
// remote reader model: carrier, field and lock levels seen by the tag
`timescale 1ns/1ps
module reader_field_model (
  // control from the bench
  input  wire logic field_on,
  input  wire logic lock_on,
  // rf levels towards the tag
  output logic      carrier_clock,
  output logic      field_sense,
  output logic      lock_sense
);
  // carrier of 160 ns, still while the field is off
  initial begin
    carrier_clock = 1'b0;
    #3.3;
    forever begin
      #80;
      carrier_clock = field_on ? ~carrier_clock : 1'b0;
    end
  end
  // lock only exists while a field is there
  assign field_sense = field_on;
  assign lock_sense  = field_on & lock_on;
endmodule : reader_field_model

// >>> testbench.sv
// self-checking bench for the tag register bank
`timescale 1ns/1ps
module testbench;
  import nfc_tag_regs_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        cyc, stb, we, ack, field_on, lock_on, carrier, field_s, lock_s;
  logic        ok, sleep_st, tx_go, tx_to, tx_pend, f_par, f_drop, f_sof, f_crc;
  logic [11:0] adr;
  logic [3:0]  sel, err_set, rxr_set;
  logic [31:0] dat_i, dat_o, buf_addr, irq_en, r, ptr;
  logic [4:0]  ev;
  logic [2:0]  tag_state;
  logic [8:0]  idx, s;
  logic [8:0]  iv [4];
  logic [31:0] exp_q [$];
  string       name_q [$];
  logic [31:0] rnd = 32'h0000_1AAD;
  int          errors, comparisons, i, t, lo, hi;
  logic [11:0] ro [9] = '{OFS_WIN_OPEN, OFS_WIN_CLOSE, OFS_MODE, OFS_TX_FORMAT, OFS_PTR,
                          OFS_SIZE, OFS_SLEEP, OFS_ERROR, OFS_INT_DISABLE};
  logic [31:0] rv [9] = '{32'h480, 32'h1000, 32'h1, 32'h17, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  int          evb [4] = '{3, 2, 1, 2};
  int          cl [5] = '{140, 140, 140, 140, 120};
  int          cc [5] = '{0, 100, 140, 128, 121};
  int          md [5] = '{0, 1, 2, 3, 3};

  always #5 clock = ~clock;

  reader_field_model reader (.field_on(field_on), .lock_on(lock_on), .carrier_clock(carrier),
                             .field_sense(field_s), .lock_sense(lock_s));

  nfc_tag_frame_timing_regs uut (
    .clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .carrier_clock(carrier), .field_sense(field_s), .lock_sense(lock_s),
    .rx_frame_end(ev[0]), .sleep_request_valid(ev[1]), .go_idle_task(ev[2]),
    .go_sleep_task(ev[3]), .start_transmit_task(ev[4]), .error_set(err_set),
    .rx_result_set(rxr_set), .tag_operating_state(tag_state), .buffer_index(idx),
    .buffer_address(buf_addr), .buffer_access_ok(ok), .irq_enable(irq_en),
    .anticollision_sleep_state(sleep_st), .tx_go(tx_go), .tx_timeout(tx_to),
    .tx_pending(tx_pend), .tx_parity_enable(f_par), .unused_bit_drop_side(f_drop),
    .tx_sof_enable(f_sof), .tx_checksum_mode(f_crc));

  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs

  task automatic report_and_stop();
    $display("counts: comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      errors++;
      $display("mismatch bus ack expected 1 seen 0");
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
  endtask : wb

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic fire(input int b);
    ev[b] <= 1'b1;
    @(posedge clock);
    ev <= 5'h00;
    @(posedge clock);
  endtask : fire

  // read data watcher against the oldest noted expectation
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(name_q.pop_front(), dat_o, exp_q.pop_front());
    end
  end

  initial begin
    {cyc, stb, we, adr, sel, dat_i, ev, err_set, rxr_set, tag_state, idx} = '0;
    {field_on, lock_on} = 2'b00;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 9; i++) rd("reset value", ro[i], rv[i]);
    rd("unmapped read", 12'h600, 32'h0);
    $display("test done: reset values");
    wr(OFS_INT_SET, 32'hFFFF_FFFF);
    rd("enables after set", OFS_INT_DISABLE, IRQ_IMPL_MASK);
    wr(OFS_INT_DISABLE, 32'h0010_0005);
    rd("enables after disable", OFS_INT_SET, IRQ_IMPL_MASK & 32'hFFEF_FFFA);
    wr(OFS_INT_SET, 32'h0010_0000);
    rd("started enable", OFS_INT_SET, IRQ_IMPL_MASK & 32'hFFFF_FFFA);
    check("irq output", irq_en, IRQ_IMPL_MASK & 32'hFFFF_FFFA);
    $display("test done: interrupt enables");
    r = xs() | 32'h1;
    err_set <= 4'hF;
    rxr_set <= r[3:0];
    tag_state <= r[6:4];
    @(posedge clock);
    {err_set, rxr_set} <= 8'h00;
    rd("error flags", OFS_ERROR, 32'hF);
    wr(OFS_ERROR, 32'h5);
    rd("error after clear", OFS_ERROR, 32'hA);
    wr(OFS_RX_RESULT, 32'h0);
    rd("rx result kept", OFS_RX_RESULT, {28'h0, r[3:0]});
    wr(OFS_RX_RESULT, 32'hF);
    rd("rx result cleared", OFS_RX_RESULT, 32'h0);
    rd("tag state", OFS_TAG_STATE, {29'h0, r[6:4]});
    $display("test done: status flags");
    for (i = 0; i < 4; i++) begin
      fire(evb[i]);
      rd("sleep state", OFS_SLEEP, (evb[i] == 2) ? 32'h0 : 32'h1);
      check("sleep output", {31'h0, sleep_st}, (evb[i] == 2) ? 32'h0 : 32'h1);
    end
    $display("test done: sleep state");
    field_on <= 1'b1;
    lock_on <= 1'b1;
    repeat (4) @(posedge clock);
    rd("field and lock", OFS_FIELD, 32'h3);
    lock_on <= 1'b0;
    repeat (4) @(posedge clock);
    rd("field without lock", OFS_FIELD, 32'h1);
    $display("test done: field presence");
    wr(OFS_SIZE, 32'd300);
    rd("size clamped", OFS_SIZE, SIZE_MAX);
    ptr = xs();
    s = 9'(xs() % 257 + 1);
    wr(OFS_PTR, ptr);
    wr(OFS_SIZE, {23'h0, s});
    rd("pointer", OFS_PTR, ptr);
    iv = '{9'h000, s - 9'h001, s, 9'h1FF};
    for (i = 0; i < 4; i++) begin
      idx <= iv[i];
      repeat (2) @(posedge clock);
      check("buffer address", buf_addr, ptr + {23'h0, iv[i]});
      check("buffer access ok", {31'h0, ok}, {31'h0, iv[i] < s});
    end
    $display("test done: buffer");
    wr(OFS_TX_FORMAT, 32'h0);
    check("format outputs", {28'h0, f_crc, f_sof, f_drop, f_par}, 32'h0);
    wr(OFS_TX_FORMAT, 32'hFFFF_FFFF);
    rd("format", OFS_TX_FORMAT, 32'h17);
    check("format outputs", {28'h0, f_crc, f_sof, f_drop, f_par}, 32'hF);
    $display("test done: frame format");
    wr(OFS_WIN_OPEN, 32'd100);
    // 16 clocks a carrier cycle, plus sync and phase slack
    for (i = 0; i < 5; i++) begin
      wr(OFS_WIN_CLOSE, cl[i]);
      wr(OFS_MODE, md[i]);
      fire(0);
      fire(4);
      check("tx pending", {31'h0, tx_pend}, 32'h1);
      t = 4;
      while (tx_go !== 1'b1 && tx_to !== 1'b1 && t < 4000) begin
        @(posedge clock);
        t++;
      end
      lo = (i == 0) ? 5 : cc[i] * 16 - 16;
      hi = (i == 0) ? 5 : cc[i] * 16 + 24;
      check("tx outcome", {30'h0, tx_to, tx_go}, (i == 4) ? 32'h2 : 32'h1);
      check("tx pending cleared", {31'h0, tx_pend}, 32'h0);
      check("tx cycle in range", {31'h0, t >= lo && t <= hi}, 32'h1);
      if (t >= 4000) report_and_stop();
      $display("test done: timing mode %0d close %0d after %0d cycles", md[i], cl[i], t);
    end
    report_and_stop();
  end
endmodule : testbench
